// *** design/pc_stack_pkg.sv ***
// Constants and types shared by the instruction pointer and its return stack
package ptr_stack_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int PTR_W = 9;
  localparam int LOW_W = 8;
  localparam int STACK_W = 12;
  localparam int STACK_DEPTH = 4;
  localparam int PAGE_W = 2;
  localparam int LIT_W = 8;

  // ****************************************
  // Reset values and fixed figures
  // ****************************************
  // All ones: last word of the last page, the reset vector
  localparam logic [PTR_W-1:0] PTR_RESET = 9'h1FF;
  localparam logic [PAGE_W-1:0] PAGE_RESET = 2'h0;
  localparam logic [PTR_W-1:0] PTR_STEP = 9'h001;
  localparam logic [STACK_W-1:0] RET_STEP = 12'h001;
  // One above the highest target reachable by a call or a computed jump
  localparam logic [PTR_W-1:0] LOWER_HALF_LIMIT = 9'h100;
  localparam logic [STACK_W-PTR_W-1:0] RET_PAD = 3'h0;

  // ****************************************
  // Source of the next pointer value
  // ****************************************
  typedef enum logic [2:0] {
    SRC_STEP = 3'b000,
    SRC_JUMP = 3'b001,
    SRC_CALL = 3'b010,
    SRC_LOW = 3'b011,
    SRC_RETURN = 3'b100
  } ptr_src_t;

endpackage : ptr_stack_pkg

// *** design/return_stack_store.sv ***
// Four-level return address store, kept through every reset
`timescale 1ns/1ps
module return_stack_store
  import ptr_stack_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Shift controls
  input wire logic push,
  input wire logic pop,
  input wire logic [STACK_W-1:0] pushData,
  // Level contents, level one in the low bits
  output logic [STACK_W*STACK_DEPTH-1:0] levels
);

  // ****************************************
  // Storage
  // ****************************************
  logic [STACK_W-1:0] level [STACK_DEPTH];

  // No reset on purpose: return addresses survive a device reset
  genvar i;
  generate
    for (i = 0; i < STACK_DEPTH; i++) begin : g_level
      if (i == 0) begin : g_top
        always_ff @(posedge ref_clk) begin
          if (push) begin
            level[i] <= pushData;
          end else if (pop) begin
            level[i] <= level[i+1];
          end
        end
      end else if (i == STACK_DEPTH - 1) begin : g_bottom
        // Deepest level only takes from above; a pop leaves it as is
        always_ff @(posedge ref_clk) begin
          if (push) begin
            level[i] <= level[i-1];
          end
        end
      end else begin : g_mid
        always_ff @(posedge ref_clk) begin
          if (push) begin
            level[i] <= level[i-1];
          end else if (pop) begin
            level[i] <= level[i+1];
          end
        end
      end
      assign levels[i*STACK_W +: STACK_W] = level[i];
    end
  endgenerate

endmodule : return_stack_store

// *** design/program_counter_return_stack.sv ***
// Instruction pointer sequencing with a four-level hardware return stack
// Notes on behaviour
// - Pointer steps by one each instruction cycle unless an instruction loads it.
// - A jump loads all nine pointer bits from the instruction word.
// - Calls and low-byte writes load eight low bits; the ninth bit goes to zero.
// - Any write to the pointer low byte counts as a pointer load.
// - Call and computed-jump targets therefore stay in the lower 256 words.
// - Any reset sets the pointer to all ones, the reset vector.
// - Any reset clears the page preselect bits.
// - The return stack is last-in first-out, four levels of twelve bits.
// - A call shifts level one down, then stores pointer plus one in level one.
// - Beyond four calls only the four newest return addresses remain.
// - A literal return loads the pointer from level one, then shifts levels up.
// - Beyond four returns the deepest level keeps supplying its old address.
// - A literal return also loads the accumulator with its literal.
// - Stack contents survive every reset.
// - No overflow or underflow flag exists; only calls and returns move the stack.
`timescale 1ns/1ps
module program_counter_return_stack
  import ptr_stack_pkg::*;
(
  // Clock and reset; one ref_clk edge is one instruction cycle
  input wire logic ref_clk,
  input wire logic resetn,
  // Decoded instruction, at most one strobe high per cycle
  input wire logic jumpInstruction,
  input wire logic callInstruction,
  input wire logic literalReturn,
  input wire logic pointerLowByteWrite,
  input wire logic [PTR_W-1:0] instrTarget,
  input wire logic [LOW_W-1:0] pointerLowByteData,
  input wire logic [LIT_W-1:0] instrLiteral,
  // Page preselect write from the status word
  input wire logic pageWrite,
  input wire logic [PAGE_W-1:0] pageWriteData,
  // Sequencing outputs
  output logic [PTR_W-1:0] instrPointer,
  output logic [PAGE_W-1:0] pageSelect,
  // Accumulator load
  output logic accumLoad,
  output logic [LIT_W-1:0] accumData,
  // Stack view, level one in the low bits
  output logic [STACK_W*STACK_DEPTH-1:0] stackLevels
);

  // ****************************************
  // Decode
  // ****************************************
  ptr_src_t ptrSrc;
  logic [PTR_W-1:0] next_instrPointer;
  logic [STACK_W-1:0] returnAddress;
  logic [STACK_W-1:0] stackTop;
  logic doPush;
  logic doPop;

  // Return beats call beats jump beats low write; decoder should never overlap them
  assign ptrSrc = literalReturn ? SRC_RETURN :
                  callInstruction ? SRC_CALL :
                  jumpInstruction ? SRC_JUMP :
                  pointerLowByteWrite ? SRC_LOW : SRC_STEP;
  // Stack moves only on calls and returns, never by any other path
  assign doPush = (ptrSrc == SRC_CALL);
  assign doPop = (ptrSrc == SRC_RETURN);
  assign returnAddress = {RET_PAD, instrPointer} + RET_STEP;
  assign stackTop = stackLevels[STACK_W-1:0];

  // Next pointer selection
  always_comb begin
    case (ptrSrc)
      SRC_JUMP: next_instrPointer = instrTarget;
      SRC_CALL: next_instrPointer = {1'b0, instrTarget[LOW_W-1:0]};
      SRC_LOW: next_instrPointer = {1'b0, pointerLowByteData};
      SRC_RETURN: next_instrPointer = stackTop[PTR_W-1:0];
      SRC_STEP: next_instrPointer = instrPointer + PTR_STEP;
      default: next_instrPointer = instrPointer + PTR_STEP;
    endcase
  end

  // ****************************************
  // Pointer and page registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      instrPointer <= PTR_RESET;
    end else begin
      instrPointer <= next_instrPointer;
    end
  end

  // Page bits cleared so the jump at the reset vector lands in page zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pageSelect <= PAGE_RESET;
    end else if (pageWrite) begin
      pageSelect <= pageWriteData;
    end
  end

  // Accumulator gets the literal of a return, as a one-cycle load
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      accumLoad <= 1'b0;
      accumData <= '0;
    end else begin
      accumLoad <= doPop;
      accumData <= doPop ? instrLiteral : accumData;
    end
  end

  // ****************************************
  // Return stack
  // ****************************************
  // Unreset storage keeps its contents through reset; no depth counter, so no flags
  return_stack_store i_return_stack_store (
    .ref_clk(ref_clk),
    .push(doPush),
    .pop(doPop),
    .pushData(returnAddress),
    .levels(stackLevels)
  );

  // ****************************************
  // Assertions
  // ****************************************
  logic plainCycle;
  assign plainCycle = !(jumpInstruction || callInstruction || literalReturn || pointerLowByteWrite);

  property p_step;
    @(posedge ref_clk) disable iff (!resetn)
      plainCycle |=> instrPointer == $past(instrPointer) + PTR_STEP;
  endproperty
  a_step: assert property (p_step) else $error("pointer did not step by one");

  property p_jump;
    @(posedge ref_clk) disable iff (!resetn)
      (jumpInstruction && !callInstruction && !literalReturn) |=> instrPointer == $past(instrTarget);
  endproperty
  a_jump: assert property (p_jump) else $error("jump target not loaded");

  property p_call_load;
    @(posedge ref_clk) disable iff (!resetn)
      (callInstruction && !literalReturn) |=> instrPointer == {1'b0, $past(instrTarget[LOW_W-1:0])};
  endproperty
  a_call_load: assert property (p_call_load) else $error("call target wrong");

  property p_low_write;
    @(posedge ref_clk) disable iff (!resetn)
      (pointerLowByteWrite && !jumpInstruction && !callInstruction && !literalReturn)
        |=> instrPointer == {1'b0, $past(pointerLowByteData)};
  endproperty
  a_low_write: assert property (p_low_write) else $error("low byte write not taken");

  property p_lower_half;
    @(posedge ref_clk) disable iff (!resetn)
      ((callInstruction || pointerLowByteWrite) && !jumpInstruction && !literalReturn)
        |=> instrPointer < LOWER_HALF_LIMIT;
  endproperty
  a_lower_half: assert property (p_lower_half) else $error("target above lower half");

  property p_reset_vector;
    @(posedge ref_clk) $rose(resetn) |-> (instrPointer == PTR_RESET && pageSelect == PAGE_RESET);
  endproperty
  a_reset_vector: assert property (p_reset_vector) else $error("reset values wrong");

  // Levels are unknown from power-up until filled, so the push, still and reset-keep checks compare level copies four-state
  property p_push;
    @(posedge ref_clk) disable iff (!resetn)
      (callInstruction && !literalReturn) |=> stackTop == $past(returnAddress)
        && stackLevels[2*STACK_W-1:STACK_W] === $past(stackTop);
  endproperty
  a_push: assert property (p_push) else $error("call push wrong");

  property p_push_drop;
    @(posedge ref_clk) disable iff (!resetn)
      (callInstruction && !literalReturn)
        |=> stackLevels[4*STACK_W-1:3*STACK_W] === $past(stackLevels[3*STACK_W-1:2*STACK_W]);
  endproperty
  a_push_drop: assert property (p_push_drop) else $error("level four not from level three");

  property p_pop;
    @(posedge ref_clk) disable iff (!resetn)
      literalReturn |=> instrPointer == $past(stackTop[PTR_W-1:0])
        && stackTop == $past(stackLevels[2*STACK_W-1:STACK_W]);
  endproperty
  a_pop: assert property (p_pop) else $error("return pop wrong");

  property p_pop_bottom;
    @(posedge ref_clk) disable iff (!resetn)
      literalReturn |=> stackLevels[4*STACK_W-1:3*STACK_W] == $past(stackLevels[4*STACK_W-1:3*STACK_W]);
  endproperty
  a_pop_bottom: assert property (p_pop_bottom) else $error("deepest level changed on pop");

  property p_literal;
    @(posedge ref_clk) disable iff (!resetn)
      literalReturn |=> accumLoad && accumData == $past(instrLiteral) ##1 !accumLoad || $past(literalReturn);
  endproperty
  a_literal: assert property (p_literal) else $error("literal not loaded");

  property p_still;
    @(posedge ref_clk) disable iff (!resetn)
      (!callInstruction && !literalReturn) |=> stackLevels === $past(stackLevels);
  endproperty
  a_still: assert property (p_still) else $error("stack moved without call or return");

  property p_keep_on_reset;
    @(posedge ref_clk) (!resetn && !callInstruction && !literalReturn) |=> stackLevels === $past(stackLevels);
  endproperty
  a_keep_on_reset: assert property (p_keep_on_reset) else $error("stack lost in reset");

  // Main scenarios
  c_call_return: cover property (@(posedge ref_clk) disable iff (!resetn)
    callInstruction ##[1:8] literalReturn);
  c_five_calls: cover property (@(posedge ref_clk) disable iff (!resetn)
    (callInstruction && !literalReturn) [*5]);
  c_five_returns: cover property (@(posedge ref_clk) disable iff (!resetn) literalReturn [*5]);
  c_computed_jump: cover property (@(posedge ref_clk) disable iff (!resetn)
    pointerLowByteWrite && plainCycle == 1'b0);

endmodule : program_counter_return_stack

// *** bench/test_program_counter_return_stack.sv ***
// Self-checking bench for the instruction pointer and its return stack
`timescale 1ns/1ps
module test_program_counter_return_stack;
  import ptr_stack_pkg::*;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic jumpInstruction = 1'b0;
  logic callInstruction = 1'b0;
  logic literalReturn = 1'b0;
  logic pointerLowByteWrite = 1'b0;
  logic [PTR_W-1:0] instrTarget = 9'h000;
  logic [LOW_W-1:0] pointerLowByteData = 8'h00;
  logic [LIT_W-1:0] instrLiteral = 8'h00;
  logic pageWrite = 1'b0;
  logic [PAGE_W-1:0] pageWriteData = 2'h0;
  logic [PTR_W-1:0] instrPointer;
  logic [PAGE_W-1:0] pageSelect;
  logic accumLoad;
  logic [LIT_W-1:0] accumData;
  logic [STACK_W*STACK_DEPTH-1:0] stackLevels;
  int errCount = 0;
  int nChecks = 0;
  int cycles = 0;
  logic [PTR_W-1:0] ep;
  logic [STACK_W-1:0] lv [4];

  program_counter_return_stack i_program_counter_return_stack (
    .ref_clk(ref_clk), .resetn(resetn), .jumpInstruction(jumpInstruction),
    .callInstruction(callInstruction), .literalReturn(literalReturn),
    .pointerLowByteWrite(pointerLowByteWrite), .instrTarget(instrTarget),
    .pointerLowByteData(pointerLowByteData), .instrLiteral(instrLiteral), .pageWrite(pageWrite),
    .pageWriteData(pageWriteData), .instrPointer(instrPointer), .pageSelect(pageSelect),
    .accumLoad(accumLoad), .accumData(accumData), .stackLevels(stackLevels));

  // 20 MHz instruction clock; the cycle ceiling cuts a hang short
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      errCount++;
      summarize();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [47:0] e, input logic [47:0] g);
    nChecks++;
    if (g !== e) begin
      errCount++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask : chk

  // One instruction: set at the falling edge, look just after the taking edge
  task automatic drive(input logic j, c, r, w, input logic [8:0] t, input logic [7:0] d, l);
    @(negedge ref_clk);
    jumpInstruction = j;
    callInstruction = c;
    literalReturn = r;
    pointerLowByteWrite = w;
    instrTarget = t;
    pointerLowByteData = d;
    instrLiteral = l;
    @(posedge ref_clk);
    #1;
  endtask : drive

  function automatic logic [47:0] packLv();
    return {lv[3], lv[2], lv[1], lv[0]};
  endfunction : packLv

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset();
    repeat (4) @(posedge ref_clk);
    #1;
    chk("pointer", 48'(PTR_RESET), 48'(instrPointer));
    chk("page", 48'(PAGE_RESET), 48'(pageSelect));
    chk("accum load", 48'h0, 48'(accumLoad));
    @(negedge ref_clk);
    resetn = 1'b1;
    ep = 9'h1FF;
    // First edge after release already steps off the reset vector and wraps to zero
    @(posedge ref_clk);
    #1;
    chk("pointer", 48'h000, 48'(instrPointer));
    $display("test_reset done");
  endtask : test_reset

  // Plain cycles step on from word zero; unused fields must not matter
  task automatic test_step();
    drive(0, 0, 0, 0, 9'h0AA, 8'h55, 8'h00);
    chk("pointer", 48'h001, 48'(instrPointer));
    repeat (3) drive(0, 0, 0, 0, 9'h1FF, 8'hFF, 8'h00);
    chk("pointer", 48'h004, 48'(instrPointer));
    $display("test_step done");
  endtask : test_step

  // A jump keeps bit eight, a low byte write clears it right after
  task automatic test_jump_low();
    drive(1, 0, 0, 0, 9'h1A5, 8'h00, 8'h00);
    chk("pointer", 48'h1A5, 48'(instrPointer));
    drive(0, 0, 0, 1, 9'h1C3, 8'h7E, 8'h00);
    chk("pointer", 48'h07E, 48'(instrPointer));
    ep = 9'h07E;
    $display("test_jump_low done");
  endtask : test_jump_low

  // Five calls back to back: the oldest return address falls off
  task automatic test_calls();
    logic [8:0] t;
    for (int i = 0; i < 5; i++) begin
      t = {1'b1, 8'h30 + 8'(i * 8)};
      drive(0, 1, 0, 0, t, 8'h00, 8'h00);
      lv[3] = lv[2];
      lv[2] = lv[1];
      lv[1] = lv[0];
      lv[0] = {3'h0, ep} + 12'h001;
      ep = {1'b0, t[7:0]};
      chk("pointer", 48'(ep), 48'(instrPointer));
      chk("level one", 48'(lv[0]), 48'(stackLevels[11:0]));
    end
    chk("levels", packLv(), stackLevels);
    $display("test_calls done");
  endtask : test_calls

  // Six returns: the deepest address keeps coming back
  task automatic test_returns();
    for (int i = 0; i < 6; i++) begin
      drive(0, 0, 1, 0, 9'h1FF, 8'hFF, 8'hA0 + 8'(i));
      ep = lv[0][8:0];
      lv[0] = lv[1];
      lv[1] = lv[2];
      lv[2] = lv[3];
      chk("pointer", 48'(ep), 48'(instrPointer));
      chk("levels", packLv(), stackLevels);
      chk("accum load", 48'h1, 48'(accumLoad));
      chk("accum data", 48'hA0 + 48'(i), 48'(accumData));
    end
    drive(0, 0, 0, 0, 9'h000, 8'h00, 8'h11);
    chk("accum load", 48'h0, 48'(accumLoad));
    chk("accum data", 48'hA5, 48'(accumData));
    chk("pointer", 48'(ep + 9'h001), 48'(instrPointer));
    chk("levels", packLv(), stackLevels);
    $display("test_returns done");
  endtask : test_returns

  // Reset in mid-run sets the pointer to all ones and clears the page but leaves the stack alone
  task automatic test_reset_mid();
    @(negedge ref_clk);
    pageWrite = 1'b1;
    pageWriteData = 2'h3;
    @(posedge ref_clk);
    #1;
    chk("page", 48'h3, 48'(pageSelect));
    @(negedge ref_clk);
    pageWrite = 1'b0;
    resetn = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("pointer", 48'h1FF, 48'(instrPointer));
    chk("page", 48'h0, 48'(pageSelect));
    chk("levels", packLv(), stackLevels);
    @(negedge ref_clk);
    resetn = 1'b1;
    @(posedge ref_clk);
    #1;
    chk("pointer", 48'h000, 48'(instrPointer));
    drive(0, 0, 0, 0, 9'h000, 8'h00, 8'h00);
    chk("pointer", 48'h001, 48'(instrPointer));
    $display("test_reset_mid done");
  endtask : test_reset_mid

  // ****************************************
  // Verdict and main sequence
  // ****************************************
  task automatic summarize();
    $display("checks %0d, mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  initial begin
    test_reset();
    test_step();
    test_jump_low();
    test_calls();
    test_returns();
    test_reset_mid();
    summarize();
  end
endmodule : test_program_counter_return_stack
